/* File: rtl/cmic_pkg.sv */
// package for the clock mode initialisation and machine clock output block
// assumes a single 100 MHz system clock; a 3-bit mode code is the machine clock half period minus one, in reference ticks
package cmic_pkg;

    localparam int unsigned CMIC_MODE_W    = 3;
    localparam int unsigned CMIC_CNT_W     = 3;
    localparam int unsigned CMIC_CLK_MHZ   = 100;
    localparam logic [1:0]  CMIC_RST_SYNC0 = 2'h0;
    localparam logic        CMIC_MCLK_RST  = 1'h0;
    localparam logic        CMIC_OE_RST    = 1'h0;
    localparam logic [CMIC_CNT_W-1:0] CMIC_CNT_RST = 3'h0;

    typedef logic [CMIC_MODE_W-1:0] cmic_mode_t;

    // software write request for the clock mode register
    typedef struct packed {
        logic       valid;
        cmic_mode_t data;
    } cmic_mode_wr_t;

    // the three mode select pins
    typedef struct packed {
        logic c;
        logic b;
        logic a;
    } cmic_sel_pins_t;

endpackage : cmic_pkg

/* File: rtl/cmic_top.sv */
// clock mode register with reset-time pin capture, and machine clock output
// assumes inputs synchronous to CLOCK_IN and that CLOCK_IN runs while reset is held
// Operation
// - while reset is low, sample the three clock mode select pins every clock
// - the mode register starts from the sampled pin levels after reset
// - after reset, software may rewrite the clock mode register
// - after reset, mode select pins have no effect until next reset
// - machine clock output completes one period per machine cycle
// - global output-disable low drives the machine clock output enable low one clock later
// - without the internal oscillator, the reference comes from the external clock pin
`timescale 1ns/10ps
`default_nettype none

module cmic_top
    import cmic_pkg::*;
(
    input  wire logic           CLOCK_IN,
    input  wire logic           RESETN_IN,
    input  wire cmic_sel_pins_t CLOCK_MODE_SELECT_IN,
    input  wire logic           EXTERNAL_CLOCK_INPUT_IN,
    input  wire logic           OSCILLATOR_ENABLE_IN,
    input  wire logic           OUTPUTS_OFF_N_IN,
    input  wire cmic_mode_wr_t  MODE_WRITE_IN,
    output var  cmic_mode_t     CLOCK_MODE_OUT,
    output var  logic           MACHINE_CLOCK_OUT,
    output var  logic           MACHINE_CLOCK_OE_OUT,
    output var  logic           CRYSTAL_DRIVE_OUTPUT_OUT
);

    logic [1:0]            rst_sync_q;
    logic                  rst_n_q;
    cmic_mode_t            mode_q;
    cmic_mode_t            mode_d;
    cmic_mode_t            pin_mode;
    logic                  ext_q;
    logic                  ext_prev_q;
    logic                  ext_rise;
    logic                  ref_tick;
    logic [CMIC_CNT_W-1:0] cnt_q;
    logic [CMIC_CNT_W-1:0] cnt_d;
    logic                  half_done;
    logic                  mclk_q;
    logic                  oe_q;
    logic                  xtal_q;

    // half period of the machine clock in reference ticks, minus one
    function automatic logic [CMIC_CNT_W-1:0] half_limit(input cmic_mode_t m);
        half_limit = m;
    endfunction : half_limit

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rst_sync_q <= CMIC_RST_SYNC0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n_q = rst_sync_q[1];

    assign pin_mode = {CLOCK_MODE_SELECT_IN.c, CLOCK_MODE_SELECT_IN.b, CLOCK_MODE_SELECT_IN.a};

    // capture is clocked rather than async-loaded so no port feeds a reset value
    assign mode_d = !rst_n_q            ? pin_mode :
                    MODE_WRITE_IN.valid ? MODE_WRITE_IN.data :
                                          mode_q;

    always_ff @(posedge CLOCK_IN) begin
        mode_q <= mode_d;
    end
    assign CLOCK_MODE_OUT = mode_q;

    // external pin is treated as a slow synchronous reference, so only rising edges count
    assign ext_rise  = ext_q & ~ext_prev_q;
    assign ref_tick  = OSCILLATOR_ENABLE_IN ? 1'b1 : ext_rise;
    assign half_done = ref_tick && (cnt_q == half_limit(mode_q));
    assign cnt_d     = half_done ? CMIC_CNT_RST :
                       ref_tick  ? cnt_q + 3'h1 : cnt_q;

    always_ff @(posedge CLOCK_IN or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ext_q      <= 1'h0;
            ext_prev_q <= 1'h0;
            cnt_q      <= CMIC_CNT_RST;
            mclk_q     <= CMIC_MCLK_RST;
            oe_q       <= CMIC_OE_RST;
            xtal_q     <= 1'h0;
        end else begin
            ext_q      <= EXTERNAL_CLOCK_INPUT_IN;
            ext_prev_q <= ext_q;
            cnt_q      <= cnt_d;
            mclk_q     <= mclk_q ^ half_done;
            oe_q       <= OUTPUTS_OFF_N_IN;
            xtal_q     <= OSCILLATOR_ENABLE_IN & ~ext_q;
        end
    end

    assign MACHINE_CLOCK_OUT        = mclk_q;
    assign MACHINE_CLOCK_OE_OUT     = oe_q;
    // crystal drive stays quiet when the oscillator is unused, as the pin is left open
    assign CRYSTAL_DRIVE_OUTPUT_OUT = xtal_q;

    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!rst_n_q);

    pin_capture_a: assert property (disable iff (1'b0) !rst_n_q |=> mode_q == $past(pin_mode))
        else $error("mode register did not follow pins during reset");
    mode_init_a: assert property (disable iff (1'b0) $rose(rst_n_q) |-> mode_q == $past(pin_mode))
        else $error("mode register not initialised from pins");
    sw_write_a: assert property (MODE_WRITE_IN.valid |=> CLOCK_MODE_OUT == $past(MODE_WRITE_IN.data))
        else $error("software mode write not taken");
    pins_ignored_a: assert property (rst_n_q && !MODE_WRITE_IN.valid |=> $stable(CLOCK_MODE_OUT))
        else $error("mode changed without a write after reset");
    mclk_toggle_a: assert property (half_done |=> MACHINE_CLOCK_OUT != $past(MACHINE_CLOCK_OUT))
        else $error("machine clock missed a half period");
    mclk_hold_a: assert property (rst_n_q && !half_done |=> $stable(MACHINE_CLOCK_OUT))
        else $error("machine clock toggled early");
    // a mode change can leave the counter above the new limit, so only a zero count is a fixed point
    fast_period_a: assert property (OSCILLATOR_ENABLE_IN && mode_q == 3'h0 && cnt_q == 3'h0
                                    |=> MACHINE_CLOCK_OUT != $past(MACHINE_CLOCK_OUT))
        else $error("machine clock period wrong for mode zero");
    off_hiz_a: assert property (!OUTPUTS_OFF_N_IN |=> !MACHINE_CLOCK_OE_OUT)
        else $error("machine clock driven while outputs off");
    // the enable flop leaves reset one edge after the internal reset rises, hence the rst_n_q term
    off_drive_a: assert property (rst_n_q && OUTPUTS_OFF_N_IN |=> MACHINE_CLOCK_OE_OUT)
        else $error("machine clock not driven while outputs on");
    xtal_quiet_a: assert property (rst_n_q && !OSCILLATOR_ENABLE_IN |=> !CRYSTAL_DRIVE_OUTPUT_OUT)
        else $error("crystal drive active without the oscillator");
    ext_ref_a: assert property (!OSCILLATOR_ENABLE_IN && !ext_rise |=> $stable(cnt_q))
        else $error("reference advanced without an external clock edge");

    write_cov: cover property (MODE_WRITE_IN.valid ##1 MODE_WRITE_IN.valid);
    ext_run_cov: cover property (!OSCILLATOR_ENABLE_IN && half_done);
    off_cov: cover property (!OUTPUTS_OFF_N_IN ##1 OUTPUTS_OFF_N_IN);
    init_cov: cover property (disable iff (1'b0) $rose(rst_n_q) && mode_q != 3'h0);
    fast_cov: cover property (OSCILLATOR_ENABLE_IN && mode_q == 3'h0 && half_done);

endmodule : cmic_top

`default_nettype wire

/* File: testbench/cmic_ext_src.sv */
// free-running external reference clock model
// assumes clk_in is the bench clock; one period is 2*HALF of its cycles
`timescale 1ns/10ps
`default_nettype none
module cmic_ext_src #(
    parameter int HALF = 3
) (
    input  wire logic clk_in,
    output var  logic ext_out
);
    int cnt = 0;
    initial ext_out = 1'b0;
    // an oscillator never stops, so edges keep coming through reset too
    always @(posedge clk_in) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) ext_out <= #2 ~ext_out;
    end
endmodule : cmic_ext_src
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking bench for the clock mode block
// assumes the model reference has a 6-cycle period
`timescale 1ns/10ps
`default_nettype none
module tb;
    import cmic_pkg::*;
    logic           clk, rst_n, osc, off_n, ext, mclk, oe, prv, xtal;
    cmic_sel_pins_t sel;
    cmic_mode_wr_t  wr;
    cmic_mode_t     mode;
    int             mismatches, tests_run, c;
    wire            mclk_w;
    assign mclk_w = oe ? mclk : 1'bz;
    cmic_ext_src #(.HALF(3)) src_u (.clk_in(clk), .ext_out(ext));
    cmic_top dut_u (.CLOCK_IN(clk), .RESETN_IN(rst_n), .CLOCK_MODE_SELECT_IN(sel),
        .EXTERNAL_CLOCK_INPUT_IN(ext), .OSCILLATOR_ENABLE_IN(osc), .OUTPUTS_OFF_N_IN(off_n),
        .MODE_WRITE_IN(wr), .CLOCK_MODE_OUT(mode), .MACHINE_CLOCK_OUT(mclk),
        .MACHINE_CLOCK_OE_OUT(oe), .CRYSTAL_DRIVE_OUTPUT_OUT(xtal));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask : chk
    task close_out;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task wr_mode(input cmic_mode_t m);
        wr = '{1'b1, m};
        step(1);
        wr.valid = 1'b0;
        chk(mode === m, "mode readback");
    endtask : wr_mode
    // cycles between the second and third rises after a mode change; the earlier rises are skipped
    task period;
        repeat (3) begin
            c = 0;
            do begin
                prv = mclk;
                step(1);
                c++;
            end while (!(prv === 1'b0 && mclk === 1'b1) && c < 200);
            if (c >= 200) begin
                mismatches++;
                close_out();
            end
        end
    endtask : period
    task t_reset(input cmic_mode_t m);
        rst_n = 1'b0;
        sel = m;
        step(12);
        rst_n = 1'b1;
        step(3);
        chk(mode === m, "pin capture");
        sel = ~m;
        step(4);
        chk(mode === m, "pins ignored");
    endtask : t_reset
    task t_div(input cmic_mode_t m, input int want);
        wr_mode(m);
        period();
        chk(c == want, "machine clock period");
    endtask : t_div
    initial begin
        {rst_n, osc, off_n, wr, sel, mismatches, tests_run} = '0;
        osc = 1'b1;
        off_n = 1'b1;
        t_reset(3'h5);
        t_div(3'h0, 2);
        t_div(3'h2, 6);
        off_n = 1'b0;
        step(2);
        chk(mclk_w === 1'bz, "not floated");
        off_n = 1'b1;
        step(2);
        chk(mclk_w !== 1'bz, "not driven");
        osc = 1'b0;
        t_div(3'h0, 12);
        chk(xtal === 1'b0, "crystal drive not quiet");
        t_reset(3'h6);
        close_out();
    end
endmodule : tb
`default_nettype wire
